/* psc_pkg.sv */
// Constants, register map and encodings for the port reset/shutdown block.
// Assumes a byte-wide register space reached over the serial slave link.
// Notes on behaviour
// - Kill input low turns that port's FET off
// - Autonomous strap high at reset: ports start automatic
// - Autonomous strap low at reset: ports start shutdown
// - Autonomous strap captured only at power-up or reset
// - Software may leave automatic mode while strap high
// - Tone loss shuts and blocks AC-enabled ports
// - Four address straps give sixteen slave addresses
// - Reset on supply, pin, software bit, or overtemperature
// - Reset restores registers and latches all straps
// - Strap changes outside reset are ignored
// - No address acknowledge while reset cause persists
// - Port reset bit: power off, clear event/status
// - Port reset leaves configuration registers untouched
// - Four port modes: auto, semi, manual, shutdown
// - Fault interrupt held low while any event stands
// - Slave address is 010 plus latched straps
// - Midspan strap latched at reset; high means midspan
package psc_pkg;
  localparam int NPORT = 4;

  // Register offsets
  localparam logic [7:0] REG_EVENT  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_STRAP  = 8'h11;
  localparam logic [7:0] REG_MODE   = 8'h12;
  localparam logic [7:0] REG_AC_EN  = 8'h13;
  localparam logic [7:0] REG_POWER  = 8'h19;
  localparam logic [7:0] REG_RESET  = 8'h1A;

  // Field positions
  localparam int RST_SOFT_BIT = 4;
  localparam int PWR_OFF_LSB  = 4;

  // Port operating modes
  typedef enum logic [1:0] {
    PSC_MODE_SHUT   = 2'h0,
    PSC_MODE_MANUAL = 2'h1,
    PSC_MODE_SEMI   = 2'h2,
    PSC_MODE_AUTO   = 2'h3
  } psc_mode_e;

  // Fixed upper part of the seven-bit slave address
  localparam logic [2:0] ADDR_HIGH = 3'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Tone comparator trip level, millivolts, realised outside this logic
  localparam int TONE_FAIL_MV = 2000;

  // Serial slave states, one-hot
  typedef enum logic [6:0] {
    LS_IDLE = 7'h01,
    LS_ADDR = 7'h02,
    LS_AACK = 7'h04,
    LS_WR   = 7'h08,
    LS_WACK = 7'h10,
    LS_RD   = 7'h20,
    LS_RACK = 7'h40
  } psc_link_e;
endpackage

/* psc_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes its output is only trusted a few edges after power-up.
`timescale 1ns/100ps
module psc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } psc_sync_s;

  psc_sync_s s_q;
  psc_sync_s s_d;
  logic [W-1:0] agree;

  // Filter moves only when stages two and three agree
  always_comb begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    agree  = ~(s_q.s2 ^ s_q.s3);
    s_d.f  = (agree & s_q.s3) | (~agree & s_q.f);
  end

  // No reset: a pure pipeline flushes itself within four edges
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign q = s_q.f;
endmodule

/* psc_reset_ctl.sv */
// Reset, strap latch, port kill and tone-loss shutdown with serial slave.
// Assumes scl and data pins are oversampled on link_clk, pins are async.
`timescale 1ns/100ps
module psc_reset_ctl (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      link_clk,
  input  wire logic                      scl,
  input  wire logic                      serial_data_in,
  output logic                           serial_data_out,
  output logic                           serial_data_oe,
  input  wire logic                      hw_reset_n,
  input  wire logic                      supply_low_lockout,
  input  wire logic                      thermal_shutdown,
  input  wire logic                      tone_loss,
  input  wire logic [psc_pkg::NPORT-1:0] port_kill_n,
  input  wire logic                      auto_strap,
  input  wire logic                      midspan_strap,
  input  wire logic [3:0]                slave_addr_straps,
  output logic      [psc_pkg::NPORT-1:0] port_fet_on,
  output logic                           midspan_mode,
  output logic                           fault_irq_n,
  output logic                           fault_irq_oe
);
  import psc_pkg::*;

  typedef struct packed {
    logic [2*NPORT-1:0] mode;
    logic [NPORT-1:0]   ac_en;
    logic [NPORT-1:0]   fet;
    logic [2*NPORT-1:0] evt;
    logic               soft_pend;
    logic               auto_lat;
    logic               mid_lat;
    logic [3:0]         addr_lat;
    logic               req_seen;
    logic               ack_tgl;
    logic [7:0]         rd;
    logic               irq_oe;
  } psc_core_s;

  typedef struct packed {
    psc_link_e  st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] rd_sh;
    logic [7:0] ptr;
    logic       rw;
    logic       first;
    logic       ack_ok;
    logic       oe;
    logic       sda_o;
    logic       scl_p;
    logic       sda_p;
    logic       req_tgl;
    logic       req_wr;
    logic [7:0] req_ptr;
    logic [7:0] req_data;
    logic       ack_seen;
    logic [7:0] rd_data;
  } psc_link_s;

  psc_core_s c_q;
  psc_core_s c_d;
  psc_link_s l_q;
  psc_link_s l_d;

  // Synchronised pins and crossings, core side
  logic             hw_rst_f;
  logic             supply_low_lockout_f;
  logic             therm_f;
  logic             tone_f;
  logic [NPORT-1:0] kill_f;
  logic             auto_f;
  logic             mid_f;
  logic [3:0]       addr_f;
  logic             req_s;
  // Link side
  logic             lrst_b_l;
  logic             scl_f;
  logic             sda_f;
  logic             busy_l;
  logic             ack_s;

  logic             cause;
  logic             dev_rst;
  logic [NPORT-1:0] port_shut;
  logic [NPORT-1:0] tone_blk;
  logic [NPORT-1:0] off;
  logic [NPORT-1:0] port_rst;
  logic [NPORT-1:0] pwr_on;
  logic [NPORT-1:0] pwr_off;
  logic [7:0]       evt_clr;
  logic             new_req;
  logic             scl_r;
  logic             scl_fall;
  logic             start;
  logic             stop;

  // Pin inputs and the link request toggle into the system clock domain
  psc_sync #(.W(15)) u_core_sync (
    .clk (clk),
    .d   ({hw_reset_n, supply_low_lockout, thermal_shutdown, tone_loss,
           port_kill_n, auto_strap, midspan_strap, slave_addr_straps,
           l_q.req_tgl}),
    .q   ({hw_rst_f, supply_low_lockout_f, therm_f, tone_f, kill_f, auto_f, mid_f,
           addr_f, req_s})
  );

  // Pins and core state into the link clock domain
  psc_sync #(.W(5)) u_link_sync (
    .clk (link_clk),
    .d   ({rst_b, scl, serial_data_in, cause, c_q.ack_tgl}),
    .q   ({lrst_b_l, scl_f, sda_f, busy_l, ack_s})
  );

  // Reset sources; the pin holds reset while low, releases on rise
  assign cause   = ~hw_rst_f | supply_low_lockout_f | therm_f;
  assign dev_rst = ~rst_b | cause | c_q.soft_pend;

  // Per-port mode decode
  for (genvar gp = 0; gp < NPORT; gp++) begin : g_port
    assign port_shut[gp] = (c_q.mode[2*gp +: 2] == PSC_MODE_SHUT);
  end

  assign tone_blk = {NPORT{tone_f}} & c_q.ac_en;
  assign new_req  = (req_s != c_q.req_seen);

  // Core next state: register access, port power, events, reset
  always_comb begin
    c_d          = c_q;
    port_rst     = '0;
    pwr_on       = '0;
    pwr_off      = '0;
    evt_clr      = 8'h00;
    c_d.soft_pend = 1'b0;
    if (new_req) begin
      c_d.req_seen = req_s;
      c_d.ack_tgl  = ~c_q.ack_tgl;
    end
    // Read mux; command registers always read zero
    if (new_req && !l_q.req_wr) begin
      case (l_q.req_ptr)
        REG_EVENT:  c_d.rd = c_q.evt;
        REG_STATUS: c_d.rd = {tone_blk, c_q.fet};
        REG_STRAP:  c_d.rd = {2'h0, c_q.addr_lat, c_q.mid_lat, c_q.auto_lat};
        REG_MODE:   c_d.rd = c_q.mode;
        REG_AC_EN:  c_d.rd = {4'h0, c_q.ac_en};
        default:    c_d.rd = 8'h00;
      endcase
    end
    // Writes; unmapped offsets are dropped
    if (new_req && l_q.req_wr) begin
      case (l_q.req_ptr)
        REG_EVENT: evt_clr = l_q.req_data;
        REG_MODE:  c_d.mode = l_q.req_data;
        REG_AC_EN: c_d.ac_en = l_q.req_data[NPORT-1:0];
        REG_POWER: begin
          pwr_on  = l_q.req_data[NPORT-1:0];
          pwr_off = l_q.req_data[PWR_OFF_LSB +: NPORT];
        end
        REG_RESET: begin
          port_rst      = l_q.req_data[NPORT-1:0];
          c_d.soft_pend = l_q.req_data[RST_SOFT_BIT];
        end
        default: ;
      endcase
    end
    // Any shutdown cause wins over a power-on request
    off     = ~kill_f | tone_blk | port_shut | pwr_off | port_rst;
    c_d.fet = (c_q.fet | (pwr_on & ~port_shut)) & ~off;
    // New events set over a clear in the same cycle
    c_d.evt = (c_q.evt & ~evt_clr & ~{port_rst, port_rst})
              | {tone_blk & c_q.fet, ~kill_f & c_q.fet};
    c_d.irq_oe = |c_d.evt;
    // Whole-device reset: defaults and strap capture, every cycle held
    if (dev_rst) begin
      c_d.mode = auto_f ? {NPORT{PSC_MODE_AUTO}}
                        : {NPORT{PSC_MODE_SHUT}};
      c_d.ac_en     = '0;
      c_d.fet       = '0;
      c_d.evt       = '0;
      c_d.irq_oe    = 1'b0;
      c_d.soft_pend = 1'b0;
      c_d.auto_lat  = auto_f;
      c_d.mid_lat   = mid_f;
      c_d.addr_lat  = addr_f;
    end
    if (!rst_b) begin
      c_d.req_seen = 1'b0;
      c_d.ack_tgl  = 1'b0;
      c_d.rd       = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    c_q <= c_d;
  end

  // Serial line events, on filtered samples only
  assign scl_r    = scl_f & ~l_q.scl_p;
  assign scl_fall = ~scl_f & l_q.scl_p;
  assign start    = scl_f & l_q.scl_p & l_q.sda_p & ~sda_f;
  assign stop     = scl_f & l_q.scl_p & ~l_q.sda_p & sda_f;

  // Link next state: byte-level slave with pointer register
  always_comb begin
    l_d       = l_q;
    l_d.scl_p = scl_f;
    l_d.sda_p = sda_f;
    if (ack_s != l_q.ack_seen) begin
      l_d.ack_seen = ack_s;
      l_d.rd_data  = c_q.rd; // Held stable by the handshake
    end
    if (busy_l) begin
      l_d.st = LS_IDLE;
      l_d.oe = 1'b0;
    end else if (start) begin
      l_d.st    = LS_ADDR;
      l_d.cnt   = 4'h0;
      l_d.oe    = 1'b0;
      l_d.first = 1'b1;
    end else if (stop) begin
      l_d.st = LS_IDLE;
      l_d.oe = 1'b0;
    end else begin
      unique case (l_q.st)
        LS_IDLE: ;
        LS_ADDR, LS_WR: begin
          if (scl_r) begin
            l_d.sh  = {l_q.sh[6:0], sda_f};
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (scl_fall && l_q.cnt == BYTE_BITS) begin
            l_d.cnt = 4'h0;
            if (l_q.st == LS_ADDR) begin
              if (l_q.sh[7:1] == {ADDR_HIGH, c_q.addr_lat}) begin
                l_d.st = LS_AACK;
                l_d.oe = 1'b1;
                l_d.rw = l_q.sh[0];
                if (l_q.sh[0]) begin
                  l_d.req_tgl = ~l_q.req_tgl;
                  l_d.req_wr  = 1'b0;
                  l_d.req_ptr = l_q.ptr;
                end
              end else begin
                l_d.st = LS_IDLE;
              end
            end else begin
              l_d.st = LS_WACK;
              l_d.oe = 1'b1;
              if (l_q.first) begin
                l_d.ptr   = l_q.sh;
                l_d.first = 1'b0;
              end else begin
                l_d.req_tgl  = ~l_q.req_tgl;
                l_d.req_wr   = 1'b1;
                l_d.req_ptr  = l_q.ptr;
                l_d.req_data = l_q.sh;
                l_d.ptr      = l_q.ptr + 8'h01;
              end
            end
          end
        end
        LS_AACK: begin
          if (scl_fall) begin
            l_d.cnt = 4'h0;
            if (l_q.rw) begin
              l_d.st    = LS_RD;
              l_d.rd_sh = l_q.rd_data;
              l_d.oe    = ~l_q.rd_data[7];
            end else begin
              l_d.st = LS_WR;
              l_d.oe = 1'b0;
            end
          end
        end
        LS_WACK: begin
          if (scl_fall) begin
            l_d.st = LS_WR;
            l_d.oe = 1'b0;
          end
        end
        LS_RD: begin
          if (scl_r) begin
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (l_q.cnt == BYTE_BITS) begin
              l_d.st  = LS_RACK;
              l_d.oe  = 1'b0;
              l_d.cnt = 4'h0;
            end else begin
              l_d.rd_sh = {l_q.rd_sh[6:0], 1'b0};
              l_d.oe    = ~l_q.rd_sh[6];
            end
          end
        end
        LS_RACK: begin
          // Prefetch the next byte while the master acknowledges
          if (scl_r) begin
            l_d.ack_ok = ~sda_f;
            l_d.ptr    = l_q.ptr + 8'h01;
            if (!sda_f) begin
              l_d.req_tgl = ~l_q.req_tgl;
              l_d.req_wr  = 1'b0;
              l_d.req_ptr = l_q.ptr + 8'h01;
            end
          end else if (scl_fall) begin
            if (l_q.ack_ok) begin
              l_d.st    = LS_RD;
              l_d.rd_sh = l_q.rd_data;
              l_d.oe    = ~l_q.rd_data[7];
            end else begin
              l_d.st = LS_IDLE;
            end
          end
        end
        default: l_d.st = LS_IDLE;
      endcase
    end
    l_d.sda_o = ~l_d.oe;
    if (!lrst_b_l) begin
      l_d       = '0;
      l_d.st    = LS_IDLE;
      l_d.sda_o = 1'b1;
      l_d.scl_p = 1'b1;
      l_d.sda_p = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  // Outputs straight from flops, except fault_irq_n tied low
  assign port_fet_on     = c_q.fet;
  assign midspan_mode    = c_q.mid_lat;
  assign fault_irq_n     = 1'b0;
  assign fault_irq_oe    = c_q.irq_oe;
  assign serial_data_out = l_q.sda_o;
  assign serial_data_oe  = l_q.oe;

  // Checks on the core domain
  a_kill_fet_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    (~kill_f != '0) |=> ((c_q.fet & ~$past(kill_f)) == '0))
    else $error("killed port still powered");
  a_auto_start: assert property (
    @(posedge clk) disable iff (!rst_b)
    (dev_rst && auto_f) |=> (c_q.mode == {NPORT{PSC_MODE_AUTO}}))
    else $error("auto strap did not give auto mode");
  a_shut_start: assert property (
    @(posedge clk) disable iff (!rst_b)
    (dev_rst && !auto_f) |=> (c_q.mode == {NPORT{PSC_MODE_SHUT}}))
    else $error("low strap did not give shutdown mode");
  a_strap_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    !dev_rst |=> $stable({c_q.auto_lat, c_q.mid_lat, c_q.addr_lat}))
    else $error("strap latch moved outside reset");
  a_tone_block: assert property (
    @(posedge clk) disable iff (!rst_b)
    (tone_blk != '0) |=> ((c_q.fet & $past(tone_blk)) == '0))
    else $error("tone loss did not shut the port");
  a_soft_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    (new_req && l_q.req_wr && l_q.req_ptr == REG_RESET
     && l_q.req_data[RST_SOFT_BIT]) |=> c_q.soft_pend ##1
    (c_q.ac_en == '0 && c_q.evt == '0))
    else $error("software reset not applied");
  a_port_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    (port_rst != '0) |=> ((c_q.fet & $past(port_rst)) == '0))
    else $error("port reset left power on");
  a_port_cfg_keep: assert property (
    @(posedge clk) disable iff (!rst_b)
    (port_rst != '0 && !dev_rst && !c_d.soft_pend)
    |=> (c_q.mode == $past(c_q.mode) && c_q.ac_en == $past(c_q.ac_en)))
    else $error("port reset touched configuration");
  a_fault_irq: assert property (
    @(posedge clk) disable iff (!rst_b)
    (c_q.evt != '0) |-> fault_irq_oe)
    else $error("fault line released with events");
  a_cmd_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    (new_req && !l_q.req_wr && l_q.req_ptr == REG_RESET)
    |=> (c_q.rd == 8'h00))
    else $error("reset command read nonzero");
  // Link domain: no acknowledge while a reset cause stands
  a_addr_nack: assert property (
    @(posedge link_clk) disable iff (!lrst_b_l)
    busy_l |=> (l_q.st == LS_IDLE && !serial_data_oe))
    else $error("slave active during reset cause");

  c_soft_rst: cover property (@(posedge clk) disable iff (!rst_b)
    c_q.soft_pend);
  c_tone_off: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(|(c_q.fet & c_q.ac_en)) && tone_f);
  c_kill_evt: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(c_q.evt[0]));
  c_addr_ack: cover property (@(posedge link_clk) disable iff (!lrst_b_l)
    l_q.st == LS_AACK);
endmodule

/* psc_host.sv */
// Serial master model standing in for the system microcontroller.
// Assumes an open-drain data line with pull-up, resolved by the bench.
`timescale 1ns/100ps
module psc_host (
  input  wire logic       clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_low,
  output logic            res_vld,
  output logic [7:0]      res_byte
);
  logic smp;

  // Idle bus: clock high and still, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_vld = 1'b0;
    res_byte = 8'h00;
  end

  // Quarter bit; long phases let the slave oversample on its slow clock
  task automatic qtr();
    repeat (30) @(posedge clk);
    #1;
  endtask

  // Data moves mid-low, away from clock edges, so no false start or stop
  task automatic bit_io(input logic b);
    qtr();
    sda_low = ~b;
    qtr();
    scl = 1'b1;
    qtr();
    smp = sda;
    qtr();
    scl = 1'b0;
  endtask

  // Hand one observed byte to the bench for one clock
  task automatic emit(input logic [7:0] v);
    res_byte = v;
    res_vld = 1'b1;
    @(posedge clk);
    #1;
    res_vld = 1'b0;
  endtask

  // Start, or repeated start when the clock is already low
  task automatic start(input logic rep);
    if (rep) begin
      qtr();
      sda_low = 1'b0;
      qtr();
      scl = 1'b1;
    end
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b0;
  endtask

  task automatic stop();
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_low = 1'b0;
    qtr();
  endtask

  // Byte out, most significant bit first, then the slave's acknowledge
  task automatic put(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(v[i]);
    bit_io(1'b1);
    ack = ~smp;
  endtask

  // Byte in; the last byte of a read is not acknowledged
  task automatic get(input logic last);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1);
      v[i] = smp;
    end
    bit_io(last);
    emit(v);
  endtask

  // Address phase; the acknowledge is reported as a result
  task automatic addr(input logic [6:0] a, input logic rd, input logic rep);
    logic k;
    start(rep);
    put({a, rd}, k);
    emit({7'h00, k});
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the reset, strap and port shutdown block.
// Assumes the package, design files and host model are compiled first.
`timescale 1ns/100ps
module tb_top;
  import psc_pkg::*;

  localparam logic [7:0] MODES = {PSC_MODE_SHUT, PSC_MODE_MANUAL,
                                  PSC_MODE_SEMI, PSC_MODE_AUTO};
  logic             clk = 1'b0;
  logic             link_clk = 1'b0;
  logic             rst_b;
  logic             hw_reset_n;
  logic             supply_low_lockout;
  logic             thermal_shutdown;
  logic             tone_loss;
  logic [NPORT-1:0] port_kill_n;
  logic             auto_strap;
  logic             midspan_strap;
  logic [3:0]       slave_addr_straps;
  logic [NPORT-1:0] port_fet_on;
  logic             midspan_mode;
  logic             fault_irq_oe;
  logic             serial_data_oe;
  logic             serial_data_out;
  logic             scl;
  logic             sda_low;
  logic             res_vld;
  logic [7:0]       res_byte;
  logic [6:0]       dev_a;
  logic [7:0]       strap_x;
  logic [31:0]      rs = 32'h000021A1;
  logic [7:0]       exp_q[$];
  string            nam_q[$];
  int               failures = 0;
  int               num_checks = 0;
  wire              sda = ~(sda_low | serial_data_oe);

  // System clock, and a link clock unrelated in phase
  always #5 clk = ~clk;
  initial begin
    #3.3;
    forever #32 link_clk = ~link_clk;
  end

  psc_reset_ctl dut (
    .clk, .rst_b, .link_clk, .scl, .serial_data_in(sda),
    .serial_data_out, .serial_data_oe, .hw_reset_n, .supply_low_lockout,
    .thermal_shutdown, .tone_loss, .port_kill_n, .auto_strap,
    .midspan_strap, .slave_addr_straps, .port_fet_on, .midspan_mode,
    .fault_irq_n(), .fault_irq_oe
  );

  psc_host host (
    .clk, .sda, .scl, .sda_low, .res_vld, .res_byte
  );

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic check(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic note(input string n, input logic [7:0] e);
    nam_q.push_back(n);
    exp_q.push_back(e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Every test ends after a stop: the data line must be released
  task automatic done(input string n);
    check("data idle", {6'h00, serial_data_oe, serial_data_out}, 8'h01);
    $display("test %s finished", n);
  endtask

  task automatic fet(input logic [3:0] e);
    check("fet", {4'h0, port_fet_on}, {4'h0, e});
  endtask

  task automatic irq(input logic e);
    check("irq", {7'h00, fault_irq_oe}, {7'h00, e});
  endtask

  // Pointer byte, then two data bytes into consecutive registers
  task automatic wr(input logic [7:0] r, input logic [15:0] d);
    logic k;
    note("addr ack", 8'h01);
    host.addr(dev_a, 1'b0, 1'b0);
    host.put(r, k);
    host.put(d[15:8], k);
    host.put(d[7:0], k);
    host.stop();
  endtask

  // Three-byte read from r through a repeated start
  task automatic rd(input logic [7:0] r, input logic [23:0] e,
                    input string n);
    logic k;
    note("addr ack", 8'h01);
    note("addr ack", 8'h01);
    for (int i = 2; i >= 0; i--)
      note(n, e[8*i +: 8]);
    host.addr(dev_a, 1'b0, 1'b0);
    host.put(r, k);
    host.addr(dev_a, 1'b1, 1'b1);
    for (int i = 2; i >= 0; i--)
      host.get(i == 0);
    host.stop();
  endtask

  task automatic new_straps(input logic au);
    logic [31:0] v;
    v = rnd();
    auto_strap = au;
    midspan_strap = v[4];
    slave_addr_straps = v[3:0];
  endtask

  // What the device should have captured at the reset just ending
  task automatic latch();
    strap_x = {2'h0, slave_addr_straps, midspan_strap, auto_strap};
    dev_a = {ADDR_HIGH, slave_addr_straps};
  endtask

  task automatic complete_run();
    if (exp_q.size() != 0)
      failures++;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Pair each observed result with the oldest expectation
  always @(posedge clk) begin
    if (res_vld === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("CHECK FAILED result expected none seen %h", res_byte);
      end else begin
        check(nam_q.pop_front(), res_byte, exp_q.pop_front());
      end
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("CHECK FAILED run time expected end seen hang");
    complete_run();
  end

  // Main sequence; reset held long enough to reach the link domain
  initial begin
    rst_b = 1'b0;
    hw_reset_n = 1'b1;
    supply_low_lockout = 1'b0;
    thermal_shutdown = 1'b0;
    tone_loss = 1'b0;
    port_kill_n = 4'hF;
    new_straps(1'b1);
    latch();
    tick(40);
    rst_b = 1'b1;
    tick(100);
    check("midspan", {7'h00, midspan_mode}, {7'h00, strap_x[1]});
    rd(REG_STRAP, {strap_x, 8'hFF, 8'h00}, "defaults");
    done("defaults");
    auto_strap = 1'b0;
    midspan_strap = ~midspan_strap;
    slave_addr_straps = ~slave_addr_straps;
    note("no ack", 8'h00);
    host.addr(dev_a ^ 7'h01, 1'b0, 1'b0);
    host.stop();
    wr(REG_MODE, {MODES, 8'h01});
    wr(REG_POWER, 16'h0F00);
    tick(10);
    fet(4'h7);
    done("modes");
    port_kill_n = 4'hD;
    tick(10);
    fet(4'h5);
    irq(1'b1);
    port_kill_n = 4'hF;
    tone_loss = 1'b1;
    tick(10);
    fet(4'h4);
    wr(REG_POWER, 16'h0100);
    tick(10);
    fet(4'h4);
    rd(REG_STATUS, 24'h140000, "status");
    wr(REG_RESET, 16'h0600);
    tick(10);
    fet(4'h0);
    tone_loss = 1'b0;
    wr(REG_EVENT, 16'h10FF);
    tick(10);
    irq(1'b0);
    rd(REG_EVENT, 24'h000000, "events");
    rd(REG_STRAP, {strap_x, MODES, 8'h01}, "config");
    check("midspan", {7'h00, midspan_mode}, {7'h00, strap_x[1]});
    done("shutdown");
    wr(REG_POWER, 16'h0F00);
    // Pin, supply, thermal and software reset causes in turn
    for (int i = 0; i < 4; i++) begin
      new_straps(i[0]);
      tick(10);
      if (i == 3) begin
        wr(REG_RESET, 16'h1000);
      end else begin
        hw_reset_n = (i != 0);
        supply_low_lockout = (i == 1);
        thermal_shutdown = (i == 2);
        tick(10);
        fet(4'h0);
        note("no ack", 8'h00);
        host.addr(dev_a, 1'b0, 1'b0);
        host.stop();
        hw_reset_n = 1'b1;
        supply_low_lockout = 1'b0;
        thermal_shutdown = 1'b0;
      end
      latch();
      tick(100);
      check("midspan", {7'h00, midspan_mode}, {7'h00, strap_x[1]});
      rd(REG_STRAP, {strap_x, {8{i[0]}}, 8'h00}, "reset");
      done("reset cause");
    end
    complete_run();
  end
endmodule
